// File: sct_pkg.sv
// Constants, register map and carrier types for the state-configurable timer.
// Assumes a classic Wishbone master with 8-bit byte addresses and 32-bit data.
// How it works
// RULE1: Five registers, each match or capture
// RULE2: One 32-bit or two 16-bit counters
// RULE3: Counter advances on clock or input
// RULE4: Up or up-down counting per counter
// RULE5: Match can interrupt, stop, limit, reverse, toggle
// RULE6: Triggered event copies counter into capture
// RULE7: Four PWM outputs sharing one period
// RULE8: Events from match, edges, levels, combos
// RULE9: Events limit, halt, start, stop, reverse
// RULE10: Events change state, outputs, irq, DMA
// RULE11: Match zero optionally acts as limit
// RULE12: Events qualified by count direction
// RULE13: Match can stay pending until fired
// RULE14: Only events enabled in state act
// RULE15: Each event enabled per state mask
// RULE16: State survives wrap, limit and reversal
// RULE17: Outputs ORed with timer matches trigger ADC
// RULE18: Without states acts as plain timer
// RULE19: Up-down turns at zero, center aligned
// RULE20: Reset stops counters, clears state, outputs
`default_nettype none

package sct_pkg;

  localparam int NUM_MR = 5;
  localparam int NUM_EV = 6;
  localparam int NUM_IO = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  localparam logic [7:0] OFS_CAPMODE = 8'h10;
  localparam logic [7:0] OFS_OUTVAL = 8'h14;
  localparam logic [7:0] OFS_MATCH = 8'h20;
  localparam logic [7:0] OFS_CAPEV = 8'h40;
  localparam logic [7:0] OFS_EVMASK = 8'h80;
  localparam logic [7:0] OFS_EVCTL = 8'h84;
  localparam logic [7:0] OFS_OUTCTL = 8'hC0;
  localparam logic [7:0] STRIDE_WORD = 8'h04;
  localparam logic [7:0] STRIDE_EV = 8'h08;

  // Configuration bits
  localparam int CFGB_UNIFY = 0;
  localparam int CFGB_INCLK = 1;
  localparam int CFGB_INSEL = 2;
  localparam int CFGB_AUTOLIM = 4;

  // Control bits, high counter at CTL_H_SHIFT above
  localparam int CTLB_RUN = 0;
  localparam int CTLB_HALT = 1;
  localparam int CTLB_BIDIR = 2;
  localparam int CTLB_DOWN = 3;
  localparam int CTL_H_SHIFT = 16;
  localparam int STATE_H_SHIFT = 16;
  localparam int OCB_CLR = 8;

  // Event control fields
  localparam int EVB_MSEL = 0;
  localparam int EVB_HSEL = 3;
  localparam int EVB_IOCOND = 4;
  localparam int EVB_IOOUT = 6;
  localparam int EVB_IOIDX = 7;
  localparam int EVB_COMB = 9;
  localparam int EVB_STLD = 11;
  localparam int EVB_STVAL = 12;
  localparam int EVB_DIRQ = 15;
  localparam int EVB_HOLD = 17;
  localparam int EVB_LIMIT = 18;
  localparam int EVB_STOP = 19;
  localparam int EVB_START = 20;
  localparam int EVB_HALT = 21;
  localparam int EVB_REV = 22;
  localparam int EVB_IRQ = 23;
  localparam int EVB_DMA = 24;
  localparam int EVCTL_W = 25;

  typedef enum logic [3:0] {
    IO_LOW = 4'h1,
    IO_RISE = 4'h2,
    IO_FALL = 4'h4,
    IO_HIGH = 4'h8
  } io_cond_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic unify;
    logic inclk;
    logic [1:0] insel;
    logic [1:0] autolim;
    logic [1:0] run;
    logic [1:0] halt;
    logic [1:0] bidir;
    logic [1:0] down;
    logic [1:0][15:0] cnt;
    logic [1:0][2:0] state;
    logic [NUM_MR-1:0] capmode;
    logic [NUM_MR-1:0][31:0] mreg;
    logic [NUM_MR-1:0][NUM_EV-1:0] capev;
    logic [NUM_EV-1:0][7:0] evmask;
    logic [NUM_EV-1:0][EVCTL_W-1:0] evctl;
    logic [NUM_IO-1:0][NUM_EV-1:0] oset;
    logic [NUM_IO-1:0][NUM_EV-1:0] oclr;
    logic [NUM_IO-1:0] out;
    logic [NUM_IO-1:0] out_prev;
    logic [NUM_IO-1:0] in_prev;
    logic [NUM_EV-1:0] pend;
    logic [NUM_IO-1:0] trig;
    logic irq;
    logic dma;
    logic ack;
    logic [31:0] rdata;
  } sct_state_t;

  localparam sct_state_t SCT_RESET = '0;

endpackage

`default_nettype wire

// File: state_configurable_timer.sv
// Event-driven timer/PWM unit: two 16-bit or one 32-bit counter, six events, eight states.
// Assumes inputs synchronous to i_mclk and a classic Wishbone master on the register port.
`default_nettype none

module state_configurable_timer (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire sct_pkg::wb_req_t i_wb,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire logic [sct_pkg::NUM_IO-1:0] i_in,
  input wire logic [sct_pkg::NUM_IO-1:0] i_gpt_match,
  output logic [sct_pkg::NUM_IO-1:0] o_out,
  output logic [sct_pkg::NUM_IO-1:0] o_adc_trig,
  output logic o_irq_req,
  output logic o_dma_req
);
  import sct_pkg::*;

  sct_state_t r;
  sct_state_t n;
  logic tick;
  logic req;
  logic wr_en;
  logic [31:0] full;
  logic [7:0] hit_lo;
  logic [7:0] hit_hi;
  logic [1:0] adv;
  logic [1:0] lim_eff;
  logic [NUM_EV-1:0] fire;

  // Returns {down, value} after one count step
  function automatic logic [32:0] step(input logic [31:0] v, input logic lim, input logic bd,
                                       input logic dn);
    logic [32:0] res;
    res = {dn, v};
    if (!bd) begin
      res = {1'b0, (lim ? 32'h0 : v + 32'h1)};
    end else if (!dn) begin
      res = lim ? {1'b1, v - 32'h1} : {1'b0, v + 32'h1};
    end else begin
      res = (v == 32'h0) ? {1'b0, 32'h1} : {1'b1, v - 32'h1};
    end
    return res;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  always_comb begin
    logic [EVCTL_W-1:0] ctl;
    logic hs;
    logic [2:0] msel;
    logic [1:0] idx;
    logic [3:0] src;
    logic [3:0] prv;
    logic mraw;
    logic mt;
    logic io;
    logic cond;
    logic dirok;
    logic [1:0] dq;
    logic [1:0] lim_ev;
    logic [1:0] start;
    logic [1:0] stop;
    logic [1:0] halt;
    logic [1:0] rev;
    logic [1:0] st_ld;
    logic [1:0][2:0] st_val;
    logic irq;
    logic dma;
    logic [32:0] stp;
    logic s;
    logic c;
    logic [31:0] rd;
    logic [31:0] upd;
    ctl = '0;
    hs = 1'b0;
    msel = 3'h0;
    idx = 2'h0;
    src = 4'h0;
    prv = 4'h0;
    mraw = 1'b0;
    mt = 1'b0;
    io = 1'b0;
    cond = 1'b0;
    dirok = 1'b0;
    dq = 2'h0;
    lim_ev = 2'h0;
    start = 2'h0;
    stop = 2'h0;
    halt = 2'h0;
    rev = 2'h0;
    st_ld = 2'h0;
    st_val = '0;
    irq = 1'b0;
    dma = 1'b0;
    stp = '0;
    s = 1'b0;
    c = 1'b0;
    rd = 32'h0;
    upd = 32'h0;
    n = r;
    n.in_prev = i_in;
    n.out_prev = r.out;
    full = {r.cnt[1], r.cnt[0]};
    // RULE3 clock or input edge
    tick = !r.inclk || (i_in[r.insel] && !r.in_prev[r.insel]);
    // RULE1 capture slots never match
    hit_lo = 8'h0;
    hit_hi = 8'h0;
    for (int i = 0; i < NUM_MR; i++) begin
      hit_lo[i] = !r.capmode[i] && (r.unify ? (full == r.mreg[i]) : (r.cnt[0] == r.mreg[i][15:0]));
      hit_hi[i] = !r.capmode[i] && (r.cnt[1] == r.mreg[i][31:16]);
    end
    for (int h = 0; h < 2; h++) begin
      adv[h] = r.run[h] && !r.halt[h] && tick;
    end
    for (int j = 0; j < NUM_EV; j++) begin
      ctl = r.evctl[j];
      hs = !r.unify && ctl[EVB_HSEL];
      msel = ctl[EVB_MSEL +: 3];
      // RULE8 match term
      mraw = (hs ? hit_hi[msel] : hit_lo[msel]) && adv[hs];
      // RULE13 match held pending
      mt = mraw || r.pend[j];
      idx = ctl[EVB_IOIDX +: 2];
      src = ctl[EVB_IOOUT] ? r.out : i_in;
      prv = ctl[EVB_IOOUT] ? r.out_prev : r.in_prev;
      // RULE8 edge or level
      case (ctl[EVB_IOCOND +: 2])
        2'h0: io = !src[idx];
        2'h1: io = src[idx] && !prv[idx];
        2'h2: io = !src[idx] && prv[idx];
        default: io = src[idx];
      endcase
      case (ctl[EVB_COMB +: 2])
        2'h0: cond = mt || io;
        2'h1: cond = mt;
        2'h2: cond = io;
        default: cond = mt && io;
      endcase
      // RULE12 direction qualifier
      dq = ctl[EVB_DIRQ +: 2];
      dirok = (dq == 2'h1) ? !r.down[hs] : ((dq == 2'h2) ? r.down[hs] : 1'b1);
      // RULE14 RULE15 state gate
      fire[j] = cond && dirok && r.evmask[j][r.state[hs]];
      n.pend[j] = ctl[EVB_HOLD] && mt && !fire[j];
      if (fire[j]) begin
        // RULE9 counter control
        lim_ev[hs] = lim_ev[hs] | ctl[EVB_LIMIT];
        stop[hs] = stop[hs] | ctl[EVB_STOP];
        start[hs] = start[hs] | ctl[EVB_START];
        halt[hs] = halt[hs] | ctl[EVB_HALT];
        rev[hs] = rev[hs] | ctl[EVB_REV];
        // RULE10 state, irq, DMA
        if (ctl[EVB_STLD]) begin
          st_ld[hs] = 1'b1;
          st_val[hs] = ctl[EVB_STVAL +: 3];
        end
        irq = irq | ctl[EVB_IRQ];
        dma = dma | ctl[EVB_DMA];
      end
    end
    // RULE11 match zero auto limit
    lim_eff[0] = lim_ev[0] || (r.autolim[0] && hit_lo[0]);
    lim_eff[1] = lim_ev[1] || (r.autolim[1] && hit_hi[0]);
    // RULE2 RULE4 RULE18 RULE19 counting
    if (r.unify) begin
      if (adv[0]) begin
        stp = step(full, lim_eff[0], r.bidir[0], r.down[0]);
        n.down[0] = stp[32];
        n.cnt[1] = stp[31:16];
        n.cnt[0] = stp[15:0];
      end
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (adv[h]) begin
          stp = step({16'h0, r.cnt[h]}, lim_eff[h], r.bidir[h], r.down[h]);
          n.down[h] = stp[32];
          n.cnt[h] = stp[15:0];
        end
      end
    end
    // RULE5 RULE9 run, halt, reverse; RULE10 event state load here
    for (int h = 0; h < 2; h++) begin
      if (rev[h] && r.bidir[h]) begin
        n.down[h] = !r.down[h];
      end
      if (start[h]) begin
        n.run[h] = 1'b1;
      end
      if (stop[h]) begin
        n.run[h] = 1'b0;
      end
      if (halt[h]) begin
        n.halt[h] = 1'b1;
        n.run[h] = 1'b0;
      end
      if (st_ld[h]) begin
        n.state[h] = st_val[h];
      end
    end
    // RULE7 set, clear or toggle per output
    for (int k = 0; k < NUM_IO; k++) begin
      s = |(fire & r.oset[k]);
      c = |(fire & r.oclr[k]);
      if (s && c) begin
        n.out[k] = !r.out[k];
      end else if (s) begin
        n.out[k] = 1'b1;
      end else if (c) begin
        n.out[k] = 1'b0;
      end
    end
    // RULE6 capture on event
    for (int i = 0; i < NUM_MR; i++) begin
      if (r.capmode[i] && |(fire & r.capev[i])) begin
        n.mreg[i] = full;
      end
    end
    n.irq = irq;
    n.dma = dma;
    // RULE17 ADC trigger
    n.trig = r.out | i_gpt_match;

    // Bus slave: answer one cycle after the request, write lands on the ack edge
    req = i_wb.cyc && i_wb.stb;
    wr_en = req && i_wb.we && r.ack;
    n.ack = req && !r.ack;
    case (i_wb.adr)
      OFS_CFG: begin
        rd[CFGB_UNIFY] = r.unify;
        rd[CFGB_INCLK] = r.inclk;
        rd[CFGB_INSEL +: 2] = r.insel;
        rd[CFGB_AUTOLIM +: 2] = r.autolim;
      end
      OFS_CTRL: begin
        for (int h = 0; h < 2; h++) begin
          rd[CTLB_RUN + CTL_H_SHIFT * h] = r.run[h];
          rd[CTLB_HALT + CTL_H_SHIFT * h] = r.halt[h];
          rd[CTLB_BIDIR + CTL_H_SHIFT * h] = r.bidir[h];
          rd[CTLB_DOWN + CTL_H_SHIFT * h] = r.down[h];
        end
      end
      OFS_COUNT: rd = full;
      OFS_STATE: begin
        rd[2:0] = r.state[0];
        rd[STATE_H_SHIFT +: 3] = r.state[1];
      end
      OFS_CAPMODE: rd[NUM_MR-1:0] = r.capmode;
      OFS_OUTVAL: rd[NUM_IO-1:0] = r.out;
      default: begin
        for (int i = 0; i < NUM_MR; i++) begin
          if (i_wb.adr == 8'(OFS_MATCH + STRIDE_WORD * i)) rd = r.mreg[i];
          if (i_wb.adr == 8'(OFS_CAPEV + STRIDE_WORD * i)) rd[NUM_EV-1:0] = r.capev[i];
        end
        for (int j = 0; j < NUM_EV; j++) begin
          if (i_wb.adr == 8'(OFS_EVMASK + STRIDE_EV * j)) rd[7:0] = r.evmask[j];
          if (i_wb.adr == 8'(OFS_EVCTL + STRIDE_EV * j)) rd[EVCTL_W-1:0] = r.evctl[j];
        end
        for (int k = 0; k < NUM_IO; k++) begin
          if (i_wb.adr == 8'(OFS_OUTCTL + STRIDE_WORD * k)) begin
            rd[NUM_EV-1:0] = r.oset[k];
            rd[OCB_CLR +: NUM_EV] = r.oclr[k];
          end
        end
      end
    endcase
    if (req && !r.ack) begin
      n.rdata = rd;
    end
    // Software writes win over same-cycle hardware updates, except a halt set by an event
    upd = merge(rd, i_wb.dat, i_wb.sel);
    if (wr_en) begin
      case (i_wb.adr)
        OFS_CFG: begin
          n.unify = upd[CFGB_UNIFY];
          n.inclk = upd[CFGB_INCLK];
          n.insel = upd[CFGB_INSEL +: 2];
          n.autolim = upd[CFGB_AUTOLIM +: 2];
        end
        OFS_CTRL: begin
          for (int h = 0; h < 2; h++) begin
            n.run[h] = upd[CTLB_RUN + CTL_H_SHIFT * h] && !halt[h];
            n.halt[h] = upd[CTLB_HALT + CTL_H_SHIFT * h] || halt[h];
            n.bidir[h] = upd[CTLB_BIDIR + CTL_H_SHIFT * h];
            n.down[h] = upd[CTLB_DOWN + CTL_H_SHIFT * h];
          end
        end
        OFS_COUNT: begin
          n.cnt[1] = upd[31:16];
          n.cnt[0] = upd[15:0];
        end
        OFS_STATE: begin
          n.state[0] = upd[2:0];
          n.state[1] = upd[STATE_H_SHIFT +: 3];
        end
        OFS_CAPMODE: n.capmode = upd[NUM_MR-1:0];
        OFS_OUTVAL: n.out = upd[NUM_IO-1:0];
        default: begin
          for (int i = 0; i < NUM_MR; i++) begin
            if (i_wb.adr == 8'(OFS_MATCH + STRIDE_WORD * i)) n.mreg[i] = upd;
            if (i_wb.adr == 8'(OFS_CAPEV + STRIDE_WORD * i)) n.capev[i] = upd[NUM_EV-1:0];
          end
          for (int j = 0; j < NUM_EV; j++) begin
            if (i_wb.adr == 8'(OFS_EVMASK + STRIDE_EV * j)) n.evmask[j] = upd[7:0];
            if (i_wb.adr == 8'(OFS_EVCTL + STRIDE_EV * j)) n.evctl[j] = upd[EVCTL_W-1:0];
          end
          for (int k = 0; k < NUM_IO; k++) begin
            if (i_wb.adr == 8'(OFS_OUTCTL + STRIDE_WORD * k)) begin
              n.oset[k] = upd[NUM_EV-1:0];
              n.oclr[k] = upd[OCB_CLR +: NUM_EV];
            end
          end
        end
      endcase
    end
  end

  // RULE20 reset to stopped, state zero, outputs low
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      r <= SCT_RESET;
    end else begin
      r <= n;
    end
  end

  assign o_wb_ack = r.ack;
  assign o_wb_dat = r.rdata;
  assign o_out = r.out;
  assign o_adc_trig = r.trig;
  assign o_irq_req = r.irq;
  assign o_dma_req = r.dma;

  property p_reset_clear;
    @(posedge i_mclk) disable iff (!i_nrst)
    $rose(i_nrst) |-> (r.out == '0 && r.state == '0 && r.run == '0 && r.evmask == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset"); // RULE20

  property p_up_count;
    @(posedge i_mclk) disable iff (!i_nrst)
    (r.unify && adv[0] && !r.bidir[0] && !lim_eff[0] && !wr_en) |=> (full == $past(full) + 32'h1);
  endproperty
  a_up_count: assert property (p_up_count) else $error("up counter did not advance by one"); // RULE4

  property p_bottom_turn;
    @(posedge i_mclk) disable iff (!i_nrst)
    (r.unify && adv[0] && r.bidir[0] && r.down[0] && full == 32'h0 && !wr_en) |=> (!r.down[0] && full == 32'h1);
  endproperty
  a_bottom_turn: assert property (p_bottom_turn) else $error("up-down counter did not turn at zero"); // RULE19

  property p_auto_limit;
    @(posedge i_mclk) disable iff (!i_nrst)
    (r.unify && adv[0] && !r.bidir[0] && r.autolim[0] && hit_lo[0] && !wr_en) |=> (full == 32'h0);
  endproperty
  a_auto_limit: assert property (p_auto_limit) else $error("match zero limit did not clear counter"); // RULE11

  property p_split_hold;
    @(posedge i_mclk) disable iff (!i_nrst)
    (!r.unify && !r.run[1] && !wr_en) [*2] |-> $stable(r.cnt[1]);
  endproperty
  a_split_hold: assert property (p_split_hold) else $error("stopped high counter moved"); // RULE2

  property p_capture;
    @(posedge i_mclk) disable iff (!i_nrst)
    (r.capmode[1] && |(fire & r.capev[1]) && !wr_en) |=> (r.mreg[1] == $past(full));
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed counter value"); // RULE6

  property p_toggle;
    @(posedge i_mclk) disable iff (!i_nrst)
    (|(fire & r.oset[1]) && |(fire & r.oclr[1]) && !wr_en) |=> (r.out[1] != $past(r.out[1]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle"); // RULE7

  property p_irq_follow;
    @(posedge i_mclk) disable iff (!i_nrst)
    $rose(o_irq_req) |-> $past(|fire);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt request without event"); // RULE10

  property p_state_hold;
    @(posedge i_mclk) disable iff (!i_nrst)
    (!(|fire) && !wr_en) |=> $stable(r.state);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("state changed without event or write"); // RULE16

endmodule // state_configurable_timer

`default_nettype wire

// File: state_configurable_timer_tb_top.sv
// Self-checking testbench for the state-configurable timer: registers, PWM, events, states, capture.
// Assumes the design package and a Wishbone slave that acks one cycle after taking a request.
`default_nettype none

module state_configurable_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sct_pkg::*;

  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  wb_req_t wb = '0;
  logic [3:0] in_pins = 4'h0;
  logic [3:0] gpt = 4'h0;
  logic o_wb_ack;
  logic [31:0] o_wb_dat;
  logic [3:0] o_out;
  logic [3:0] o_adc_trig;
  logic o_irq_req;
  logic o_dma_req;
  int fails = 0;
  int compares = 0;
  int ticks = 0;
  int hi;
  int lo;
  int n_irq;
  int n_dma;
  logic [31:0] q;
  logic [31:0] q2;
  logic [7:0] regs [7] = '{OFS_CFG, OFS_CTRL, OFS_COUNT, OFS_STATE, OFS_CAPMODE, OFS_EVMASK, OFS_EVCTL};
  localparam logic [31:0] mo = 32'h1 << EVB_COMB;

  always #20 i_mclk = ~i_mclk;

  state_configurable_timer u_dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_wb(wb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_in(in_pins),
    .i_gpt_match(gpt), .o_out(o_out), .o_adc_trig(o_adc_trig), .o_irq_req(o_irq_req), .o_dma_req(o_dma_req));

  task automatic final_report();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The whole run takes well under a thousand cycles; this cuts a hang short
  always @(posedge i_mclk) begin
    ticks++;
    if (ticks == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // Request held until ack is seen at a rising edge, then released
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_mclk);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 16);
    q = o_wb_dat;
    if (n >= 16) begin
      chk(32'h0, 32'h1);
    end
    wb <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, 4'hF);
  endtask

  task automatic ev(input int j, input logic [7:0] m, input logic [31:0] c);
    wr(OFS_EVMASK + 8'(8 * j), {24'h0, m});
    wr(OFS_EVCTL + 8'(8 * j), c);
  endtask

  // Reset between scenarios wipes all configuration
  task automatic do_reset();
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    clk(8);
    i_nrst <= 1'b1;
  endtask

  task automatic wait_out(input logic v);
    int n;
    n = 0;
    while (o_out[0] !== v && n < 64) begin
      @(posedge i_mclk);
      n++;
    end
  endtask

  // High and low time of output 0, in clock cycles
  task automatic meas();
    wait_out(1'b0);
    wait_out(1'b1);
    hi = 0;
    lo = 0;
    while (o_out[0] === 1'b1 && hi < 64) begin
      @(posedge i_mclk);
      hi++;
    end
    while (o_out[0] === 1'b0 && lo < 64) begin
      @(posedge i_mclk);
      lo++;
    end
  endtask

  initial begin
    clk(8);
    i_nrst <= 1'b1;
    chk({28'h0, o_out}, 32'h0);
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(q, 32'h0);
    end
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC);
    chk(q, 32'h0);
    for (int i = 0; i < NUM_MR; i++) begin
      wr(OFS_MATCH + 8'(4 * i), 32'h11111111 * (i + 1));
    end
    for (int i = 0; i < NUM_MR; i++) begin
      rd(OFS_MATCH + 8'(4 * i));
      chk(q, 32'h11111111 * (i + 1));
    end
    xfer(1'b1, OFS_MATCH + 8'h10, 32'h0000AB00, 4'h2);
    rd(OFS_MATCH + 8'h10);
    chk(q, 32'h5555AB55);
    wr(OFS_CAPMODE, 32'h1F);
    rd(OFS_CAPMODE);
    chk(q, 32'h0000001F);

    // Counter ticks only on rising edges of input 2; input 1 toggles alongside
    do_reset();
    wr(OFS_CFG, (32'h1 << CFGB_INCLK) | (32'h2 << CFGB_INSEL));
    wr(OFS_CTRL, 32'h1);
    repeat (5) begin
      in_pins <= 4'h6;
      clk(3);
      in_pins <= 4'h0;
      clk(3);
    end
    wr(OFS_CTRL, 32'h0);
    rd(OFS_COUNT);
    chk(q, 32'h5);

    do_reset();
    wr(OFS_CFG, 32'h1 << CFGB_UNIFY);
    wr(OFS_COUNT, 32'h0000FFFE);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_COUNT);
    chk({16'h0, q[31:16]}, 32'h1);
    do_reset();
    wr(OFS_COUNT, 32'h0000FFFE);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_COUNT);
    chk({16'h0, q[31:16]}, 32'h0);
    chk({16'h0, q[15:0]}, 32'h1);

    // Up counting, period 6 from auto limit, set at 5 and clear at 1
    do_reset();
    wr(OFS_MATCH, 32'h5);
    wr(OFS_MATCH + 8'h04, 32'h1);
    wr(OFS_CFG, (32'h1 << CFGB_AUTOLIM) | (32'h1 << CFGB_UNIFY));
    ev(0, 8'h01, mo | (32'h1 << EVB_IRQ));
    ev(1, 8'h01, mo | (32'h1 << EVB_MSEL) | (32'h1 << EVB_DMA));
    wr(OFS_OUTCTL, 32'h00000201);
    wr(OFS_CTRL, 32'h1);
    meas();
    chk(32'(hi), 32'h2);
    chk(32'(lo), 32'h4);
    n_irq = 0;
    n_dma = 0;
    repeat (60) begin
      @(posedge i_mclk);
      if (o_irq_req === 1'b1) n_irq++;
      if (o_dma_req === 1'b1) n_dma++;
    end
    chk(32'(n_irq), 32'hA);
    chk(32'(n_dma), 32'hA);

    // Up-down to 4: set at 1 rising, clear at 1 falling
    do_reset();
    wr(OFS_MATCH, 32'h4);
    wr(OFS_MATCH + 8'h04, 32'h1);
    wr(OFS_CFG, (32'h1 << CFGB_AUTOLIM) | (32'h1 << CFGB_UNIFY));
    ev(0, 8'h01, mo | (32'h1 << EVB_MSEL) | (32'h1 << EVB_DIRQ));
    ev(1, 8'h01, mo | (32'h1 << EVB_MSEL) | (32'h2 << EVB_DIRQ));
    wr(OFS_OUTCTL, 32'h00000201);
    wr(OFS_CTRL, (32'h1 << CTLB_RUN) | (32'h1 << CTLB_BIDIR));
    meas();
    chk(32'(hi), 32'h6);
    chk(32'(lo), 32'h2);

    // States 0 to 1 to 2 across wraps, then halt; event 3 would halt early if masks were ignored
    do_reset();
    wr(OFS_MATCH, 32'h3);
    wr(OFS_MATCH + 8'h04, 32'h2);
    wr(OFS_MATCH + 8'h08, 32'h1);
    wr(OFS_CFG, 32'h1 << CFGB_AUTOLIM);
    ev(0, 8'h01, mo | (32'h1 << EVB_STLD) | (32'h1 << EVB_STVAL));
    ev(1, 8'h02, mo | (32'h1 << EVB_MSEL) | (32'h1 << EVB_STLD) | (32'h2 << EVB_STVAL));
    ev(2, 8'h04, mo | (32'h2 << EVB_MSEL) | (32'h1 << EVB_HALT));
    ev(3, 8'hF8, mo | (32'h2 << EVB_MSEL) | (32'h1 << EVB_HALT));
    wr(OFS_CTRL, 32'h1);
    clk(40);
    rd(OFS_STATE);
    chk(q, 32'h2);
    rd(OFS_CTRL);
    chk(q, 32'h1 << CTLB_HALT);
    rd(OFS_COUNT);
    q2 = q;
    clk(4);
    rd(OFS_COUNT);
    chk(q, q2);

    do_reset();
    wr(OFS_MATCH, 32'h9);
    wr(OFS_MATCH + 8'h08, 32'h4);
    wr(OFS_CFG, 32'h1 << CFGB_AUTOLIM);
    wr(OFS_CAPMODE, 32'h2);
    wr(OFS_CAPEV + 8'h04, 32'h1);
    ev(0, 8'h01, mo | (32'h2 << EVB_MSEL));
    wr(OFS_CTRL, 32'h1);
    clk(30);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_MATCH + 8'h04);
    chk(q, 32'h4);

    // High counter match held pending until input 0 is high, then stops the high counter
    do_reset();
    wr(OFS_MATCH + 8'h04, 32'h00030000);
    ev(0, 8'h01, (32'h3 << EVB_COMB) | (32'h3 << EVB_IOCOND) | (32'h1 << EVB_MSEL) | (32'h1 << EVB_HSEL)
                 | (32'h1 << EVB_HOLD) | (32'h1 << EVB_STOP));
    wr(OFS_OUTCTL, 32'h1);
    wr(OFS_CTRL, 32'h1 << CTL_H_SHIFT);
    clk(10);
    chk({28'h0, o_out}, 32'h0);
    in_pins <= 4'h1;
    clk(3);
    chk({28'h0, o_out}, 32'h1);
    rd(OFS_CTRL);
    chk(q, 32'h0);

    // Falling input 1 starts an up-down count; limit event at 6, halt at 3 only while counting down
    do_reset();
    wr(OFS_CFG, 32'h1 << CFGB_UNIFY);
    wr(OFS_MATCH, 32'h6);
    wr(OFS_MATCH + 8'h04, 32'h3);
    ev(0, 8'h01, mo | (32'h1 << EVB_LIMIT));
    ev(1, 8'h01, (32'h2 << EVB_COMB) | (32'h2 << EVB_IOCOND) | (32'h1 << EVB_IOIDX) | (32'h1 << EVB_START));
    ev(2, 8'h01, mo | (32'h1 << EVB_MSEL) | (32'h2 << EVB_DIRQ) | (32'h1 << EVB_HALT));
    wr(OFS_CTRL, 32'h1 << CTLB_BIDIR);
    in_pins <= 4'h2;
    clk(2);
    in_pins <= 4'h0;
    clk(30);
    rd(OFS_COUNT);
    chk(q, 32'h2);
    rd(OFS_CTRL);
    chk(q, 32'hE);

    // Rising edges of input 3 toggle output 1; ADC trigger merges outputs with timer matches
    do_reset();
    wr(OFS_MATCH, 32'hFF);
    wr(OFS_CFG, 32'h1 << CFGB_AUTOLIM);
    ev(0, 8'h01, (32'h2 << EVB_COMB) | (32'h1 << EVB_IOCOND) | (32'h3 << EVB_IOIDX));
    wr(OFS_OUTCTL + 8'h04, 32'h00000101);
    wr(OFS_CTRL, 32'h1);
    repeat (3) begin
      in_pins <= 4'h8;
      clk(3);
      in_pins <= 4'h0;
      clk(3);
    end
    chk({28'h0, o_out}, 32'h2);
    gpt <= 4'h9;
    clk(3);
    chk({28'h0, o_adc_trig}, 32'hB);
    final_report();
  end

endmodule // state_configurable_timer_tb_top

`default_nettype wire
